/* add_exec_pkg.sv */
// Purpose: shared constants for the add instruction datapath
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data addresses
// Notes: phase order is decode, operand read, process, destination write
package add_exec_pkg;
    localparam logic [7:0] OPC_ADD_LIT = 8'h0F;
    localparam logic [5:0] OPC_ADD_FILE = 6'h09;
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    localparam logic [7:0] INDEXED_MAX = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } phase_e;
endpackage

/* add_instruction_datapath.sv */
// Purpose: executes the literal add and the file-register add
// Assumes: i_phase_en marks one quarter of an instruction cycle
// Notes: data memory read is combinational on o_mem_addr
// Operation
// - opcode 0000 1111 kkkk kkkk adds the literal to the accumulator and updates all five flags.
// - opcode 0010 01da ffff ffff adds the accumulator to the file register and updates all flags.
// - a clear destination bit puts the sum in the accumulator and leaves the file untouched.
// - a set destination bit writes the sum back to the file register.
// - a clear bank-access bit addresses the access bank regardless of the bank select register, except where the indexed offset below applies.
// - a set bank-access bit takes the address from the bank select register and the file field.
// - extended set on, access bit clear and file field at most 95 selects indexed literal offset.
module add_instruction_datapath
    import add_exec_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_phase_en,
    input wire logic [15:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic i_ext_set_en,
    input wire logic [3:0] i_bank_select_register,
    input wire logic [11:0] i_index_base,
    input wire logic [7:0] i_mem_rdata,
    output logic [11:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    output logic o_mem_we,
    output logic [7:0] o_accumulator,
    output logic o_negative_flag,
    output logic o_signed_wrap_flag,
    output logic o_carry_flag,
    output logic o_half_carry_flag,
    output logic o_zero_flag,
    output logic o_done
);
    typedef struct packed {
        phase_e phase;
        logic is_lit;
        logic is_file;
        logic dest;
        logic [11:0] addr;
        logic [7:0] operand;
        logic [7:0] sum;
        logic [4:0] flags;
        logic [7:0] acc;
        logic [7:0] wdata;
        logic we;
        logic done;
    } state_s;

    state_s st_reg;
    state_s st_next;
    logic [8:0] full_sum;
    logic [4:0] low_sum;
    logic [11:0] file_addr;

    // indexed offset wins over the access bank when the extended set is on
    always_comb begin
        if (i_instr[ACCESS_BIT]) begin
            file_addr = {i_bank_select_register, i_instr[7:0]};
        end else if (i_ext_set_en && i_instr[7:0] <= INDEXED_MAX) begin
            file_addr = i_index_base + {4'h0, i_instr[7:0]};
        end else if (i_instr[7:0] < ACCESS_SPLIT) begin
            file_addr = {4'h0, i_instr[7:0]};
        end else begin
            file_addr = {ACCESS_HIGH_BANK, i_instr[7:0]};
        end
    end

    always_comb begin
        st_next = st_reg;
        full_sum = {1'b0, st_reg.acc} + {1'b0, st_reg.operand};
        low_sum = {1'b0, st_reg.acc[3:0]} + {1'b0, st_reg.operand[3:0]};
        st_next.we = 1'b0;
        st_next.done = 1'b0;
        if (i_phase_en) begin
            unique case (st_reg.phase)
                PH_DECODE: begin
                    st_next.is_lit = i_instr_valid && i_instr[15:8] == OPC_ADD_LIT;
                    st_next.is_file = i_instr_valid && i_instr[15:10] == OPC_ADD_FILE;
                    st_next.dest = i_instr[DEST_BIT];
                    st_next.addr = file_addr;
                    st_next.operand = i_instr[7:0];
                    st_next.phase = PH_READ;
                end
                PH_READ: begin
                    if (st_reg.is_file) begin
                        st_next.operand = i_mem_rdata;
                    end
                    st_next.phase = PH_PROCESS;
                end
                PH_PROCESS: begin
                    st_next.sum = full_sum[7:0];
                    if (st_reg.is_lit || st_reg.is_file) begin
                        // flags: n, ov, c, dc, z
                        st_next.flags = {full_sum[7],
                            (st_reg.acc[7] == st_reg.operand[7]) &&
                            (full_sum[7] != st_reg.acc[7]),
                            full_sum[8], low_sum[4], full_sum[7:0] == 8'h00};
                    end
                    st_next.phase = PH_WRITE;
                end
                PH_WRITE: begin
                    if (st_reg.is_lit || (st_reg.is_file && !st_reg.dest)) begin
                        st_next.acc = st_reg.sum;
                    end
                    if (st_reg.is_file && st_reg.dest) begin
                        st_next.we = 1'b1;
                        st_next.wdata = st_reg.sum;
                    end
                    st_next.done = st_reg.is_lit || st_reg.is_file;
                    st_next.phase = PH_DECODE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= '{phase: PH_DECODE, acc: ACC_RESET, flags: FLAGS_RESET, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_mem_addr = st_reg.addr;
    assign o_mem_wdata = st_reg.wdata;
    assign o_mem_we = st_reg.we;
    assign o_accumulator = st_reg.acc;
    assign o_negative_flag = st_reg.flags[4];
    assign o_signed_wrap_flag = st_reg.flags[3];
    assign o_carry_flag = st_reg.flags[2];
    assign o_half_carry_flag = st_reg.flags[1];
    assign o_zero_flag = st_reg.flags[0];
    assign o_done = st_reg.done;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    chk_lit_acc_write: assert property (
        (st_reg.phase == PH_WRITE && i_phase_en && st_reg.is_lit) |=> o_accumulator == $past(st_reg.sum))
        else $error("literal add did not update accumulator");
    chk_file_decode: assert property (
        (st_reg.phase == PH_DECODE && i_phase_en && i_instr_valid && i_instr[15:10] == OPC_ADD_FILE)
        |=> st_reg.is_file)
        else $error("file add not decoded");
    chk_dest_acc_keep: assert property (
        (st_reg.phase == PH_WRITE && i_phase_en && st_reg.is_file && !st_reg.dest)
        |=> !o_mem_we && o_accumulator == $past(st_reg.sum))
        else $error("destination zero mishandled");
    chk_dest_file_write: assert property (
        (st_reg.phase == PH_WRITE && i_phase_en && st_reg.is_file && st_reg.dest)
        |=> o_mem_we && o_mem_wdata == $past(st_reg.sum) && $stable(o_accumulator))
        else $error("destination one mishandled");
    chk_access_bank: assert property (
        (st_reg.phase == PH_DECODE && i_phase_en && !i_instr[ACCESS_BIT]
        && !(i_ext_set_en && i_instr[7:0] <= INDEXED_MAX))
        |=> o_mem_addr == {(($past(i_instr[7:0]) < ACCESS_SPLIT) ? 4'h0 : ACCESS_HIGH_BANK),
        $past(i_instr[7:0])})
        else $error("access bank address wrong");
    chk_bank_select: assert property (
        (st_reg.phase == PH_DECODE && i_phase_en && i_instr[ACCESS_BIT])
        |=> o_mem_addr == {$past(i_bank_select_register), $past(i_instr[7:0])})
        else $error("banked address wrong");
    chk_indexed_addr: assert property (
        (st_reg.phase == PH_DECODE && i_phase_en && !i_instr[ACCESS_BIT] && i_ext_set_en
        && i_instr[7:0] <= INDEXED_MAX)
        |=> o_mem_addr == $past(i_index_base) + {4'h0, $past(i_instr[7:0])})
        else $error("indexed address wrong");
    chk_done_once: assert property (
        o_done |-> (st_reg.phase == PH_DECODE) ##1 !o_done)
        else $error("done not a single pulse");

    // flags rebuilt from the stored sum: a wrap shows as a sum below the accumulator
    chk_lit_flags: assert property (
        (st_reg.phase == PH_PROCESS && i_phase_en && st_reg.is_lit)
        |=> o_zero_flag == (st_reg.sum == 8'h00) && o_negative_flag == st_reg.sum[7]
        && o_carry_flag == (st_reg.sum < st_reg.acc)
        && o_half_carry_flag == (st_reg.sum[3:0] < st_reg.acc[3:0])
        && o_signed_wrap_flag == (st_reg.acc[7] == st_reg.operand[7]
        && st_reg.sum[7] != st_reg.acc[7]))
        else $error("literal add flags wrong");
    chk_file_flags: assert property (
        (st_reg.phase == PH_PROCESS && i_phase_en && st_reg.is_file)
        |=> o_zero_flag == (st_reg.sum == 8'h00) && o_negative_flag == st_reg.sum[7]
        && o_carry_flag == (st_reg.sum < st_reg.acc)
        && o_half_carry_flag == (st_reg.sum[3:0] < st_reg.acc[3:0])
        && o_signed_wrap_flag == (st_reg.acc[7] == st_reg.operand[7]
        && st_reg.sum[7] != st_reg.acc[7]))
        else $error("file add flags wrong");

    chk_flags_hold: assert property (
        (st_reg.phase == PH_PROCESS && i_phase_en && !st_reg.is_lit && !st_reg.is_file)
        |=> $stable({o_negative_flag, o_signed_wrap_flag, o_carry_flag, o_half_carry_flag,
        o_zero_flag}))
        else $error("flags changed on a refused instruction");
    chk_refused_quiet: assert property (
        (st_reg.phase == PH_WRITE && i_phase_en && !st_reg.is_lit && !st_reg.is_file)
        |=> $stable(o_accumulator) && !o_mem_we && !o_done)
        else $error("refused instruction changed state");

    chk_lit_operand: assert property (
        (st_reg.phase == PH_DECODE && i_phase_en && i_instr_valid
        && i_instr[15:8] == OPC_ADD_LIT)
        |=> st_reg.is_lit && st_reg.operand == $past(i_instr[7:0]))
        else $error("literal operand not taken at decode");
    chk_file_operand: assert property (
        (st_reg.phase == PH_READ && i_phase_en && st_reg.is_file)
        |=> st_reg.operand == $past(i_mem_rdata))
        else $error("file operand not taken at read");

    chk_phase_hold: assert property (
        !i_phase_en |=> $stable(st_reg.phase))
        else $error("phase moved without an enable");
    chk_phase_advance: assert property (
        i_phase_en |=> 2'(st_reg.phase) == 2'($past(st_reg.phase) + 2'h1))
        else $error("phase did not step in order");
    chk_we_pulse: assert property (
        o_mem_we |-> (o_done && st_reg.is_file && st_reg.dest) ##1 !o_mem_we)
        else $error("write strobe not tied to a file add");

    // covers for the main scenarios
    cov_lit: cover property (o_done && st_reg.is_lit);
    cov_file_wr: cover property (o_mem_we);
    cov_carry: cover property (o_done && o_carry_flag);
    cov_indexed: cover property (st_reg.phase == PH_DECODE && i_phase_en && i_ext_set_en
        && !i_instr[ACCESS_BIT] && i_instr[7:0] <= INDEXED_MAX);
    cov_refused: cover property (st_reg.phase == PH_WRITE && i_phase_en
        && !st_reg.is_lit && !st_reg.is_file);
endmodule

/* add_instruction_datapath_tb.sv */
// Purpose: self-checking bench for the add instruction datapath
// Assumes: one phase pulse every second cycle, ports driven on the rising edge
// Notes: random instructions mix both adds, other opcodes and invalid words
module add_instruction_datapath_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import add_exec_pkg::*;
    logic i_mclk = 0, i_rst_b = 0, i_phase_en = 0, i_instr_valid = 0, i_ext_set_en = 0;
    logic [15:0] i_instr = 16'h0000;
    logic [3:0] i_bank_select_register = 4'h0, bsr_v = 4'h0;
    logic [11:0] i_index_base = 12'h000, base_v = 12'h000;
    logic [7:0] i_mem_rdata = 8'h00, acc_m = 8'h00;
    logic [11:0] o_mem_addr;
    logic [7:0] o_mem_wdata, o_accumulator;
    logic o_mem_we, o_negative_flag, o_signed_wrap_flag, o_carry_flag;
    logic o_half_carry_flag, o_zero_flag, o_done, ext_v = 0;
    logic [4:0] fl_m = 5'h00;
    logic [4:0] flags_got;
    assign flags_got = {o_negative_flag, o_signed_wrap_flag, o_carry_flag, o_half_carry_flag,
        o_zero_flag};
    int fails = 0, total_checks = 0, cyc = 0;
    add_instruction_datapath dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_phase_en(i_phase_en),
        .i_instr(i_instr), .i_instr_valid(i_instr_valid), .i_ext_set_en(i_ext_set_en),
        .i_bank_select_register(i_bank_select_register), .i_index_base(i_index_base),
        .i_mem_rdata(i_mem_rdata), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
        .o_mem_we(o_mem_we), .o_accumulator(o_accumulator), .o_negative_flag(o_negative_flag),
        .o_signed_wrap_flag(o_signed_wrap_flag), .o_carry_flag(o_carry_flag),
        .o_half_carry_flag(o_half_carry_flag), .o_zero_flag(o_zero_flag), .o_done(o_done));
    always #25 i_mclk = ~i_mclk;
    task automatic test_done;
        if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end
    task automatic check_addr(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic check_flags(input logic [4:0] got, input logic [4:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // flags in the order negative, signed wrap, carry, half carry, zero
    function automatic logic [4:0] add_flags(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[8], h[4], s[7:0] == 8'h00};
    endfunction
    function automatic logic [11:0] exp_addr(input logic [7:0] f, input logic a);
        if (a) return {bsr_v, f};
        if (ext_v && f <= INDEXED_MAX) return base_v + {4'h0, f};
        return {(f < ACCESS_SPLIT) ? 4'h0 : ACCESS_HIGH_BANK, f};
    endfunction
    task automatic pulse(input logic [15:0] ins, input logic [7:0] rd, input logic v);
        @(posedge i_mclk);
        i_instr <= ins;
        i_mem_rdata <= rd;
        i_instr_valid <= v;
        i_ext_set_en <= ext_v;
        i_bank_select_register <= bsr_v;
        i_index_base <= base_v;
        i_phase_en <= 1'b1;
        @(posedge i_mclk);
        i_phase_en <= 1'b0;
        #1;
    endtask
    task automatic exec(input logic [15:0] ins, input logic [7:0] rd, input logic v);
        logic lit, fil;
        logic [7:0] sum;
        lit = v && ins[15:8] == OPC_ADD_LIT;
        fil = v && ins[15:10] == OPC_ADD_FILE;
        sum = acc_m + (lit ? ins[7:0] : rd);
        pulse(ins, rd, v);
        if (fil) check_addr(o_mem_addr, exp_addr(ins[7:0], ins[ACCESS_BIT]));
        pulse(ins, rd, v);
        pulse(ins, rd, v);
        if (lit || fil) fl_m = add_flags(acc_m, lit ? ins[7:0] : rd);
        check_flags(flags_got, fl_m);
        pulse(ins, rd, v);
        check_bit(o_done, lit || fil);
        if (fil && ins[DEST_BIT]) begin
            check_bit(o_mem_we, 1'b1);
            check_byte(o_mem_wdata, sum);
            check_addr(o_mem_addr, exp_addr(ins[7:0], ins[ACCESS_BIT]));
        end else begin
            if (lit || fil) acc_m = sum;
            check_bit(o_mem_we, 1'b0);
        end
        check_byte(o_accumulator, acc_m);
    endtask
    initial begin
        void'($urandom(95));
        repeat (5) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        exec(16'h0F10, 8'h00, 1'b1);
        exec(16'h0F15, 8'h00, 1'b1);
        exec(16'h24C2, 8'hC2, 1'b1);
        exec(16'h0F19, 8'h00, 1'b1);
        exec(16'h0F7F, 8'h00, 1'b1);
        exec(16'h0F01, 8'h00, 1'b1);
        exec(16'h0F05, 8'h00, 1'b0);
        exec(16'h0B33, 8'h00, 1'b1);
        ext_v = 1'b1;
        bsr_v = 4'h3;
        base_v = 12'hFF0;
        exec(16'h265F, 8'h11, 1'b1);
        exec(16'h2660, 8'h22, 1'b1);
        exec(16'h2710, 8'h33, 1'b1);
        exec(16'h2481, 8'h7F, 1'b1);
        ext_v = 1'b0;
        // reset in the middle of an instruction, after its decode phase
        pulse(16'h0F40, 8'h00, 1'b1);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        #1;
        acc_m = ACC_RESET;
        fl_m = FLAGS_RESET;
        check_byte(o_accumulator, acc_m);
        check_flags(flags_got, fl_m);
        check_bit(o_done, 1'b0);
        check_bit(o_mem_we, 1'b0);
        check_addr(o_mem_addr, 12'h000);
        exec(16'h0F15, 8'h00, 1'b1);
        repeat (300) begin
            bsr_v = 4'($urandom);
            base_v = 12'($urandom);
            ext_v = 1'($urandom);
            case ($urandom % 3)
                0: exec({8'h0F, 8'($urandom)}, 8'($urandom), $urandom % 8 != 0);
                1: exec({6'h09, 10'($urandom)}, 8'($urandom), $urandom % 8 != 0);
                default: exec(16'($urandom), 8'($urandom), 1'($urandom));
            endcase
        end
        test_done();
    end
endmodule
